// ### rtl/cse_flash.sv
`timescale 1ns/1ns
module cse_flash #(
  parameter int unsigned HALF_CYC = cse_pkg::FLASH_HALF_CYC
) (
  input  logic ref_clk,
  input  logic sys_rst,
  output logic flash
);
  import cse_pkg::*;

  localparam int unsigned CW = $clog2(HALF_CYC);

  logic [CW-1:0] cnt_q;
  logic          flash_q;

  // free running half-period counter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_q   <= '0;
      flash_q <= 1'b0;
    end
    else if (cnt_q == CW'(HALF_CYC - 1))
    begin
      cnt_q   <= '0;
      flash_q <= ~flash_q;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign flash = flash_q;
endmodule : cse_flash

// ### rtl/cse_pkg.sv
package cse_pkg;
  // clock and flash timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_CODE   = 8'h08;
  localparam logic [7:0] ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADDR_ADR_LO = 8'h10;
  localparam logic [7:0] ADDR_ADR_HI = 8'h14;

  // error categories carrying a continue setting
  localparam int unsigned NCAT       = 6;
  localparam int unsigned CAT_UNIT   = 0;
  localparam int unsigned CAT_INTEL  = 1;
  localparam int unsigned CAT_VERIFY = 2;
  localparam int unsigned CAT_OPER   = 3;
  localparam int unsigned CAT_RLINK  = 4;
  localparam int unsigned CAT_RSLAVE = 5;

  // control fields
  localparam int unsigned CTL_ALLOW_DUP = 0;
  localparam int unsigned CTL_CONTINUE_ON_ERROR_SETTING_LSB  = 1;
  localparam int unsigned CTL_BATTERY_FAULT_INDICATOR_IND  = 7;
  localparam logic [7:0]  CTRL_RST      = 8'h80;

  // diagnostic codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_OPER = 8'h2D;
  localparam logic [7:0] CODE_DUP  = 8'h22;
  localparam logic [NCAT-1:0][7:0] CAT_CODE =
    {8'h20, 8'h1F, CODE_OPER, 8'h1E, 8'h1D, 8'h1C};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CSE_PROGRAM_MODE_INDICATOR = 3'b001,
    CSE_RUN  = 3'b010,
    CSE_TEST = 3'b100
  } cse_mode_e;

  typedef enum logic [7:0] {
    V_WDT   = 8'h01,
    V_HALT  = 8'h02,
    V_WAIT  = 8'h04,
    V_PROGRAM_MODE_INDICATOR  = 8'h08,
    V_RUN   = 8'h10,
    V_FORCE = 8'h20,
    V_TBRK  = 8'h40,
    V_TRUN  = 8'h80
  } cse_view_e;

  typedef struct packed {
    logic alarm;
    logic battery_fault_indicator;
    logic error;
    logic brk;
    logic test;
    logic program_mode_indicator;
    logic run;
  } cse_led_s;

  typedef struct packed {
    logic            wdt;
    logic            battery_fault_indicator_low;
    logic            rio_wait;
    logic            syntax;
    logic [3:0]      syn_code;
    logic            dup;
    logic [NCAT-1:0] cat;
    logic [31:0]     oper_addr;
  } cse_evt_s;
endpackage : cse_pkg

// ### rtl/cse_policy.sv
`timescale 1ns/1ns
module cse_policy (
  input  cse_pkg::cse_evt_s evt,
  input  logic [7:0]        ctrl,
  output logic              halt_req,
  output logic              flag_req,
  output logic              code_hit,
  output logic [7:0]        code
);
  import cse_pkg::*;

  logic [NCAT-1:0] continue_on_error_setting;
  logic            dup_err;

  function automatic logic [7:0] cat_code(input logic [NCAT-1:0] c);
    logic [7:0] r;
    r = CODE_NONE;
    for (int i = NCAT - 1; i >= 0; i--)
      if (c[i])
        r = CAT_CODE[i];
    return r;
  endfunction : cat_code

  assign continue_on_error_setting     = ctrl[CTL_CONTINUE_ON_ERROR_SETTING_LSB +: NCAT];
  assign dup_err  = evt.dup & ~ctrl[CTL_ALLOW_DUP];
  assign halt_req = evt.syntax | dup_err | (|(evt.cat & ~continue_on_error_setting));
  assign flag_req = evt.syntax | dup_err | (|evt.cat);
  assign code_hit = flag_req;

  always_comb
  begin
    if (evt.syntax)
      code = {4'h0, evt.syn_code};
    else if (dup_err)
      code = CODE_DUP;
    else
      code = cat_code(evt.cat);
  end
endmodule : cse_policy

// ### rtl/cse_status.sv
// Overview of operation
// - self-diagnosis flags errors and stops execution when the error needs it
// - by default every detected error except battery-low stops program execution
// - battery-low is flagged but execution goes on
// - with duplicate outputs allowed, a duplicate is no error and running goes on
// - operation error set to continue keeps running yet records the error
// - same continue-or-stop choice for unit, intelligent, verify, remote errors
// - indicator pattern follows operating mode and detected errors
// - run with forcing flashes run, program off, error off unless an error is recorded
// - test at break lights program and test, run off, stopped
// - test executing lights run and test, program and break off
// - halting error lights error and program, run and alarm off
// - battery error lights error and battery, execution continues
// - watchdog lights alarm and stops execution whatever else shows
// - remote slave wait flashes program, run and break off, stopped
// - codes 1 to 9 report a program syntax error
// - operation error reports code 45 to the host tool
// - watchdog expiry lights alarm and halts the controller
// - operation error captures the program address into two data registers
`timescale 1ns/1ns
module cse_status #(
  parameter int unsigned FLASH_HALF_CYC = cse_pkg::FLASH_HALF_CYC,
  parameter int unsigned ADDR_W         = 8
) (
  input  logic              ref_clk,
  input  logic              sys_rst,
  input  cse_pkg::cse_mode_e mode_sel,
  input  logic              force_act,
  input  logic              test_brk,
  input  cse_pkg::cse_evt_s evt,
  output cse_pkg::cse_led_s led,
  output logic              program_mode_indicator_exec,
  output logic [7:0]        diag_code,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready
);
  import cse_pkg::*;

  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_have_q;
  logic              awready_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              w_have_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              do_wr;
  logic              clr_wr;
  logic [7:0]        ctrl_q;
  logic              err_q;
  logic              halt_q;
  logic              wdt_q;
  logic              battery_fault_indicator_q;
  logic [7:0]        code_q;
  logic [31:0]       addr_q;
  logic              halt_req;
  logic              flag_req;
  logic              code_hit;
  logic [7:0]        code_new;
  logic              flash;
  cse_view_e         view_d;
  cse_led_s          led_d;
  cse_led_s          led_q;
  logic              exec_d;
  logic              exec_q;
  logic [31:0]       rd_d;
  logic              rd_ok;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction : hit

  cse_policy u_policy (
    .evt      (evt),
    .ctrl     (ctrl_q),
    .halt_req (halt_req),
    .flag_req (flag_req),
    .code_hit (code_hit),
    .code     (code_new)
  );

  cse_flash #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .flash   (flash)
  );

  // write address channel
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q  <= awaddr;
    end
    else if (do_wr)
      aw_have_q <= 1'b0;
    else if (bvalid_q && bready)
      awready_q <= 1'b1;
  end

  // write data channel
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end
    else if (do_wr)
      w_have_q <= 1'b0;
    else if (bvalid_q && bready)
      wready_q <= 1'b1;
  end

  assign do_wr  = aw_have_q && w_have_q && !bvalid_q;
  assign clr_wr = do_wr && hit(awaddr_q, ADDR_CLR) && mode_sel == CSE_PROGRAM_MODE_INDICATOR;

  // write response
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      if (hit(awaddr_q, ADDR_CTRL) || hit(awaddr_q, ADDR_STAT)
          || hit(awaddr_q, ADDR_CODE) || hit(awaddr_q, ADDR_CLR)
          || hit(awaddr_q, ADDR_ADR_LO) || hit(awaddr_q, ADDR_ADR_HI))
        bresp_q <= RESP_OKAY;
      else
        bresp_q <= RESP_SLVERR;
    end
    else if (bvalid_q && bready)
      bvalid_q <= 1'b0;
  end

  // per-category stop or continue settings
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ctrl_q <= CTRL_RST;
    else if (do_wr && hit(awaddr_q, ADDR_CTRL) && wstrb_q[0])
      ctrl_q <= wdata_q[7:0];
  end

  // read mux
  always_comb
  begin
    rd_d  = '0;
    rd_ok = 1'b1;
    if (hit(araddr, ADDR_CTRL))
      rd_d = {24'h0, ctrl_q};
    else if (hit(araddr, ADDR_STAT))
      rd_d = {20'h0, err_q, wdt_q, halt_q, exec_q, 1'b0, led_q};
    else if (hit(araddr, ADDR_CODE))
      rd_d = {24'h0, code_q};
    else if (hit(araddr, ADDR_ADR_LO))
      rd_d = {16'h0, addr_q[15:0]};
    else if (hit(araddr, ADDR_ADR_HI))
      rd_d = {16'h0, addr_q[31:16]};
    else if (!hit(araddr, ADDR_CLR))
      rd_ok = 1'b0;
  end

  // read channel
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_d;
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // sticky error and halt; a new error wins over a clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      err_q  <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      if (flag_req)
        err_q <= 1'b1;
      else if (clr_wr)
        err_q <= 1'b0;
      if (halt_req)
        halt_q <= 1'b1;
      else if (clr_wr)
        halt_q <= 1'b0;
    end
  end

  // diagnostic code and faulting address
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      code_q <= CODE_NONE;
    else if (code_hit)
      code_q <= code_new;
    else if (clr_wr)
      code_q <= CODE_NONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      addr_q <= '0;
    else if (evt.cat[CAT_OPER])
      addr_q <= evt.oper_addr;
  end

  // watchdog latches until reset; battery never halts
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wdt_q  <= 1'b0;
      battery_fault_indicator_q <= 1'b0;
    end
    else
    begin
      if (evt.wdt)
        wdt_q <= 1'b1;
      battery_fault_indicator_q <= evt.battery_fault_indicator_low && ctrl_q[CTL_BATTERY_FAULT_INDICATOR_IND];
    end
  end

  // indication priority
  always_comb
  begin
    if (wdt_q)
      view_d = V_WDT;
    else if (halt_q)
      view_d = V_HALT;
    else if (evt.rio_wait)
      view_d = V_WAIT;
    else
    begin
      unique case (mode_sel)
        CSE_RUN:  view_d = force_act ? V_FORCE : V_RUN;
        CSE_TEST: view_d = test_brk ? V_TBRK : V_TRUN;
        CSE_PROGRAM_MODE_INDICATOR: view_d = V_PROGRAM_MODE_INDICATOR;
        default:  view_d = V_PROGRAM_MODE_INDICATOR;
      endcase
    end
  end

  // indicator pattern per view
  always_comb
  begin
    led_d       = '0;
    led_d.error = err_q || battery_fault_indicator_q;
    led_d.battery_fault_indicator  = battery_fault_indicator_q;
    led_d.test  = mode_sel == CSE_TEST;
    exec_d      = 1'b0;
    unique case (view_d)
      V_WDT:
      begin
        led_d       = led_q;
        led_d.alarm = 1'b1;
      end
      V_HALT:
      begin
        led_d.program_mode_indicator  = 1'b1;
        led_d.error = 1'b1;
      end
      V_WAIT:
        led_d.program_mode_indicator = flash;
      V_PROGRAM_MODE_INDICATOR:
        led_d.program_mode_indicator = 1'b1;
      V_RUN:
      begin
        led_d.run = 1'b1;
        exec_d    = 1'b1;
      end
      V_FORCE:
      begin
        led_d.run = flash;
        exec_d    = 1'b1;
      end
      V_TBRK:
      begin
        led_d.program_mode_indicator = 1'b1;
        led_d.test = 1'b1;
        led_d.brk  = 1'b1;
      end
      V_TRUN:
      begin
        led_d.run  = 1'b1;
        led_d.test = 1'b1;
        exec_d     = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      led_q  <= '0;
      exec_q <= 1'b0;
    end
    else
    begin
      led_q  <= led_d;
      exec_q <= exec_d;
    end
  end

  assign led       = led_q;
  assign program_mode_indicator_exec = exec_q;
  assign diag_code = code_q;
  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_wdt_stop;
    evt.wdt |-> ##2 (led_q.alarm && !exec_q);
  endproperty
  a_wdt_stop: assert property (p_wdt_stop)
    else $error("watchdog did not light alarm and stop");

  property p_halt_led;
    (halt_req && !wdt_q && !evt.wdt) |-> ##2
      (led_q.error && led_q.program_mode_indicator && !led_q.run && !led_q.alarm && !exec_q);
  endproperty
  a_halt_led: assert property (p_halt_led)
    else $error("halting error pattern wrong");

  property p_stop_default;
    (|(evt.cat & ~ctrl_q[CTL_CONTINUE_ON_ERROR_SETTING_LSB +: NCAT])) |=> halt_q;
  endproperty
  a_stop_default: assert property (p_stop_default)
    else $error("error set to stop did not halt");

  property p_battery_fault_indicator_run;
    (evt.battery_fault_indicator_low && ctrl_q[CTL_BATTERY_FAULT_INDICATOR_IND] && !halt_req && !halt_q && !wdt_q && !evt.wdt)
      |=> !halt_q ##1 (led_q.error && led_q.battery_fault_indicator);
  endproperty
  a_battery_fault_indicator_run: assert property (p_battery_fault_indicator_run)
    else $error("battery error halted or not shown");

  property p_dup_allow;
    (evt.dup && ctrl_q[CTL_ALLOW_DUP] && !evt.syntax && evt.cat == '0 && !halt_q)
      |=> !halt_q;
  endproperty
  a_dup_allow: assert property (p_dup_allow)
    else $error("allowed duplicate output halted");

  property p_oper_continue_on_error_setting;
    (evt.cat == (NCAT'(1) << CAT_OPER) && !evt.syntax && !evt.dup && !halt_q
      && ctrl_q[CTL_CONTINUE_ON_ERROR_SETTING_LSB + CAT_OPER]) |=> (!halt_q && err_q && code_q == CODE_OPER);
  endproperty
  a_oper_continue_on_error_setting: assert property (p_oper_continue_on_error_setting)
    else $error("continued operation error not recorded");

  property p_oper_addr;
    evt.cat[CAT_OPER] |=> addr_q == $past(evt.oper_addr);
  endproperty
  a_oper_addr: assert property (p_oper_addr)
    else $error("operation error address not captured");

  property p_syn_code;
    evt.syntax |=> code_q == {4'h0, $past(evt.syn_code)};
  endproperty
  a_syn_code: assert property (p_syn_code)
    else $error("syntax code not reported");

  property p_test_brk;
    (mode_sel == CSE_TEST && test_brk && !halt_q && !wdt_q && !evt.rio_wait)
      |=> (led_q.program_mode_indicator && led_q.test && !led_q.run && !exec_q);
  endproperty
  a_test_brk: assert property (p_test_brk)
    else $error("test break pattern wrong");

  property p_test_run;
    (mode_sel == CSE_TEST && !test_brk && !halt_q && !wdt_q && !evt.rio_wait)
      |=> (led_q.run && led_q.test && !led_q.program_mode_indicator && !led_q.brk && exec_q);
  endproperty
  a_test_run: assert property (p_test_run)
    else $error("test run pattern wrong");

  property p_rio_wait;
    (evt.rio_wait && !halt_q && !wdt_q)
      |=> (!led_q.run && !led_q.brk && !exec_q && led_q.program_mode_indicator == $past(flash));
  endproperty
  a_rio_wait: assert property (p_rio_wait)
    else $error("remote wait pattern wrong");

  property p_force;
    (mode_sel == CSE_RUN && force_act && !halt_q && !wdt_q && !evt.rio_wait
      && !err_q && !battery_fault_indicator_q) |=> (!led_q.program_mode_indicator && !led_q.error && exec_q
      && led_q.run == $past(flash));
  endproperty
  a_force: assert property (p_force)
    else $error("forcing pattern wrong");
endmodule : cse_status

// ### verif/cse_status_bench.sv
`timescale 1ns/1ns
module cse_status_bench;
  import cse_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  cse_mode_e   mode_sel;
  logic        force_act;
  logic        test_brk;
  cse_evt_s    evt;
  cse_led_s    led;
  logic        program_mode_indicator_exec;
  logic [7:0]  diag_code;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [6:0]  led_v;
  int          n_mismatch;
  int          comparisons;
  logic [31:0] d;
  logic [1:0]  r;
  int          n;

  assign led_v = led;

  cse_status #(.FLASH_HALF_CYC(4)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_sel(mode_sel), .force_act(force_act),
    .test_brk(test_brk), .evt(evt), .led(led), .program_mode_indicator_exec(program_mode_indicator_exec),
    .diag_code(diag_code), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  always #5 ref_clk = ~ref_clk;

  task close_out;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task stuck;
    n_mismatch++;
    $display("unexpected at %0t: bus wait ran out", $time);
    close_out;
  endtask : stuck

  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int i;
    awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) stuck;
    @(posedge ref_clk);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int i;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) stuck;
    @(posedge ref_clk);
  endtask : rd

  task fire(input cse_evt_s e);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
    cyc(3);
  endtask : fire

  task clr;
    mode_sel <= CSE_PROGRAM_MODE_INDICATOR;
    cyc(2);
    wr(ADDR_CLR, 32'h1, r);
    mode_sel <= CSE_RUN;
    cyc(3);
  endtask : clr

  task hi_count(input int b);
    n = 0;
    repeat (16)
    begin
      @(posedge ref_clk);
      n += int'(led_v[b]);
    end
  endtask : hi_count

  task t_reset;
    cyc(2);
    chk(32'(led_v), 32'h02);
    chk(32'(program_mode_indicator_exec), 32'h0);
    rd(ADDR_CTRL, d, r);
    chk(d, 32'(CTRL_RST));
    rd(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h44, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    mode_sel <= CSE_RUN;
    cyc(3);
    chk(32'(led_v), 32'h01);
    chk(32'(program_mode_indicator_exec), 32'h1);
  endtask : t_reset

  task t_syntax;
    cse_evt_s e;
    for (int c = 1; c <= 9; c += 8)
    begin
      e = '0;
      e.syntax = 1'b1;
      e.syn_code = 4'(c);
      fire(e);
      chk(32'(diag_code), 32'(c));
      chk(32'(program_mode_indicator_exec), 32'h0);
      chk(32'(led_v & 7'h53), 32'h12);
      wr(ADDR_CLR, 32'h1, r);
      cyc(2);
      chk(32'(diag_code), 32'(c));
      clr;
      chk(32'(diag_code), 32'h0);
    end
  endtask : t_syntax

  task t_cats;
    cse_evt_s e;
    for (int k = 0; k < NCAT; k++)
      for (int s = 0; s < 2; s++)
      begin
        wr(ADDR_CTRL, 32'(CTRL_RST) | (32'(s) << (k + 1)), r);
        e = '0;
        e.cat[k] = 1'b1;
        e.oper_addr = 32'h1234ABCD;
        fire(e);
        chk(32'(program_mode_indicator_exec), 32'(s));
        chk(32'(diag_code), 32'(CAT_CODE[k]));
        rd(ADDR_STAT, d, r);
        chk(32'(d[11]), 32'h1);
        if (k == CAT_OPER)
        begin
          chk(32'(diag_code), 32'h2D);
          rd(ADDR_ADR_LO, d, r);
          chk(d, 32'hABCD);
          rd(ADDR_ADR_HI, d, r);
          chk(d, 32'h1234);
        end
        clr;
      end
  endtask : t_cats

  task t_dup;
    cse_evt_s e;
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_CTRL, 32'(CTRL_RST) | 32'(s), r);
      e = '0;
      e.dup = 1'b1;
      fire(e);
      chk(32'(program_mode_indicator_exec), 32'(s));
      chk(32'(diag_code), s ? 32'h0 : 32'(CODE_DUP));
      clr;
    end
    wr(ADDR_CTRL, 32'(CTRL_RST), r);
  endtask : t_dup

  task t_battery_fault_indicator;
    evt.battery_fault_indicator_low <= 1'b1;
    cyc(4);
    chk(32'(led_v & 7'h30), 32'h30);
    chk(32'(program_mode_indicator_exec), 32'h1);
    rd(ADDR_STAT, d, r);
    chk(32'(d[9]), 32'h0);
    evt.battery_fault_indicator_low <= 1'b0;
    cyc(4);
    chk(32'(led_v[5]), 32'h0);
    wr(ADDR_CTRL, 32'h0, r);
    evt.battery_fault_indicator_low <= 1'b1;
    cyc(4);
    chk(32'(led_v & 7'h30), 32'h0);
    chk(32'(program_mode_indicator_exec), 32'h1);
    evt.battery_fault_indicator_low <= 1'b0;
    wr(ADDR_CTRL, 32'(CTRL_RST), r);
    clr;
  endtask : t_battery_fault_indicator

  task t_modes;
    force_act <= 1'b1;
    cyc(3);
    hi_count(0);
    chk(32'(n), 32'd8);
    chk(32'(led_v & 7'h12), 32'h0);
    chk(32'(program_mode_indicator_exec), 32'h1);
    force_act <= 1'b0;
    mode_sel <= CSE_TEST;
    test_brk <= 1'b1;
    cyc(3);
    chk(32'(led_v & 7'h07), 32'h06);
    chk(32'(program_mode_indicator_exec), 32'h0);
    test_brk <= 1'b0;
    cyc(3);
    chk(32'(led_v & 7'h0F), 32'h05);
    chk(32'(program_mode_indicator_exec), 32'h1);
    mode_sel <= CSE_RUN;
    evt.rio_wait <= 1'b1;
    cyc(3);
    hi_count(1);
    chk(32'(n), 32'd8);
    chk(32'(led_v & 7'h09), 32'h0);
    chk(32'(program_mode_indicator_exec), 32'h0);
    evt.rio_wait <= 1'b0;
    cyc(3);
  endtask : t_modes

  task t_wdt;
    cse_evt_s e;
    e = '0;
    e.wdt = 1'b1;
    e.syntax = 1'b1;
    e.syn_code = 4'h3;
    fire(e);
    chk(32'(led_v[6]), 32'h1);
    chk(32'(program_mode_indicator_exec), 32'h0);
    clr;
    rd(ADDR_STAT, d, r);
    chk(32'(d[10]), 32'h1);
    chk(32'(led_v[6]), 32'h1);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(3);
    chk(32'(led_v), 32'h01);
  endtask : t_wdt

  initial
  begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    mode_sel = CSE_PROGRAM_MODE_INDICATOR;
    force_act = 1'b0;
    test_brk = 1'b0;
    evt = '0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_syntax;
    t_cats;
    t_dup;
    t_battery_fault_indicator;
    t_modes;
    t_wdt;
    close_out;
  end
endmodule : cse_status_bench
